// file: verilog/poe_port_sequencer.sv
`timescale 1ns/1ps
module poe_port_sequencer
	import poe_seq_pkg::*;
#(
	parameter int TICK_CYCLES = CYCLES_PER_MS,
	parameter int COOL_MS = COOL_MS_DEFAULT
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [1:0] auto_strap_pin,
	input wire logic [3:0] address_strap_pins,
	input wire logic [7:0] host_det_set,
	input wire logic [7:0] host_cls_set,
	input wire logic [7:0] host_power_off,
	input wire logic [15:0] power_alloc,
	input wire logic [7:0] det_done,
	input wire logic [7:0] det_ok,
	input wire logic [7:0] cls_done,
	input wire logic [7:0] cls_ok,
	input wire logic [23:0] cls_level,
	input wire logic [7:0] start_fault,
	input wire logic [7:0] policing_fault,
	input wire logic [7:0] current_limit_fault,
	input wire logic [7:0] short_fault,
	input wire logic [7:0] maint_current_pin,
	output logic [3:0] i2c_address,
	output logic [1:0] auto_mode,
	output logic [7:0] detect_enable_bit,
	output logic [7:0] class_enable_bit,
	output logic [7:0] det_run,
	output logic [7:0] cls_run,
	output logic [7:0] ext_class_run,
	output logic [7:0] port_power,
	output logic [7:0] cool_active,
	output logic [15:0] grant_level
);

	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
	localparam logic [MS_CNT_W-1:0] EXT_LAST = MS_CNT_W'(CLASS_EXT_MS - 1);
	localparam logic [MS_CNT_W-1:0] COOL_LAST = MS_CNT_W'(COOL_MS - 1);
	localparam logic [SETTLE_W-1:0] SETTLE_LAST = '1;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// ----------------------------------------
	// Strap capture and millisecond tick
	// ----------------------------------------
	logic [1:0] auto_meta;
	logic [1:0] auto_sync;
	logic [3:0] addr_meta;
	logic [3:0] addr_sync;
	logic [SETTLE_W-1:0] settle;
	logic strap_done;
	logic [TICK_W-1:0] tick_cnt;
	logic tick;
	logic [SETTLE_W-1:0] next_settle;
	logic next_strap_done;
	logic [1:0] next_auto_mode;
	logic [3:0] next_i2c_address;
	logic [TICK_W-1:0] next_tick_cnt;
	logic next_tick;

	// Straps are caught once after the synchronisers have filled, then frozen
	always_comb begin
		next_settle = settle;
		next_strap_done = strap_done;
		next_auto_mode = auto_mode;
		next_i2c_address = i2c_address;
		if (!strap_done) begin
			next_settle = settle + SETTLE_W'(1);
			if (settle == SETTLE_LAST) begin
				next_strap_done = 1'b1;
				next_i2c_address = addr_sync;
				next_auto_mode = (auto_sync == STRAP_62K) ? STRAP_62K :
					(auto_sync == STRAP_124K) ? STRAP_124K : STRAP_OPEN;
			end
		end
		next_tick = (tick_cnt == TICK_LAST);
		next_tick_cnt = next_tick ? '0 : tick_cnt + TICK_W'(1);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			auto_meta <= STRAP_OPEN;
			auto_sync <= STRAP_OPEN;
			addr_meta <= 4'h0;
			addr_sync <= 4'h0;
			settle <= '0;
			strap_done <= 1'b0;
			auto_mode <= STRAP_OPEN;
			i2c_address <= 4'h0;
			tick_cnt <= '0;
			tick <= 1'b0;
		end else begin
			auto_meta <= auto_strap_pin;
			auto_sync <= auto_meta;
			addr_meta <= address_strap_pins;
			addr_sync <= addr_meta;
			settle <= next_settle;
			strap_done <= next_strap_done;
			auto_mode <= next_auto_mode;
			i2c_address <= next_i2c_address;
			tick_cnt <= next_tick_cnt;
			tick <= next_tick;
		end
	end

	logic auto_on;
	logic [1:0] auto_limit;
	assign auto_on = (auto_mode != STRAP_OPEN);
	assign auto_limit = (auto_mode == STRAP_62K) ? ALLOC_30W : ALLOC_15W;

	// ----------------------------------------
	// Maintain check per port
	// ----------------------------------------
	logic [7:0] maint_drop;

	for (genvar g = 0; g < NUM_PORTS; g++) begin : g_maint
		maint_monitor u_maint (
			.clk(clk),
			.arst_n(arst_n),
			.tick(tick),
			.powered(port_power[g]),
			.current_pin(maint_current_pin[g]),
			.drop(maint_drop[g])
		);
	end

	// ----------------------------------------
	// Port sequencers
	// ----------------------------------------
	port_state_type state [NUM_PORTS];
	port_state_type next_state [NUM_PORTS];
	logic [MS_CNT_W-1:0] timer [NUM_PORTS];
	logic [MS_CNT_W-1:0] next_timer [NUM_PORTS];
	logic [7:0] next_det_en;
	logic [7:0] next_cls_en;
	logic [15:0] next_grant;
	logic [7:0] want_det;
	logic [7:0] want_cls;
	logic [7:0] any_fault;

	always_comb begin
		next_det_en = detect_enable_bit;
		next_cls_en = class_enable_bit;
		next_grant = grant_level;
		for (int p = 0; p < NUM_PORTS; p++) begin
			next_state[p] = state[p];
			next_timer[p] = timer[p];
			// Host set wins over a power-off in the same cycle
			if (host_power_off[p]) begin
				next_det_en[p] = 1'b0;
				next_cls_en[p] = 1'b0;
			end
			if (host_det_set[p])
				next_det_en[p] = 1'b1;
			if (host_cls_set[p])
				next_cls_en[p] = 1'b1;
			want_det[p] = next_det_en[p] | auto_on;
			want_cls[p] = next_cls_en[p] | auto_on;
			any_fault[p] = start_fault[p] | policing_fault[p] | current_limit_fault[p]
				| short_fault[p];
			if (host_power_off[p]) begin
				next_state[p] = ST_IDLE;
			end else begin
				unique case (state[p])
					ST_IDLE: begin
						next_state[p] = restart_state(want_det[p], want_cls[p]);
					end
					ST_DETECT: begin
						if (!want_det[p])
							next_state[p] = ST_IDLE;
						else if (det_done[p] && det_ok[p] && want_cls[p])
							next_state[p] = ST_CLASS;
					end
					ST_CLASS: begin
						if (cls_done[p]) begin
							next_timer[p] = '0;
							next_state[p] = cls_ok[p] ? ST_CLASS_EXT : ST_IDLE;
							next_grant[2*p +: 2] = min_alloc(class_to_alloc(cls_level[3*p +: 3]),
								auto_on ? auto_limit : power_alloc[2*p +: 2]);
						end
					end
					ST_CLASS_EXT: begin
						if (tick) begin
							next_timer[p] = timer[p] + MS_CNT_W'(1);
							if (timer[p] == EXT_LAST)
								next_state[p] = ST_POWERED;
						end
					end
					ST_POWERED: begin
						if (any_fault[p]) begin
							next_timer[p] = '0;
							next_state[p] = ST_COOL;
						end else if (maint_drop[p]) begin
							next_state[p] = restart_state(want_det[p], want_cls[p]);
						end
					end
					ST_COOL: begin
						// Enable bits set meanwhile stay pending until expiry
						if (tick) begin
							next_timer[p] = timer[p] + MS_CNT_W'(1);
							if (timer[p] == COOL_LAST)
								next_state[p] = restart_state(want_det[p], want_cls[p]);
						end
					end
					default: next_state[p] = ST_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				state[p] <= ST_IDLE;
				timer[p] <= '0;
			end
			detect_enable_bit <= 8'h00;
			class_enable_bit <= 8'h00;
			grant_level <= 16'h0000;
			det_run <= 8'h00;
			cls_run <= 8'h00;
			ext_class_run <= 8'h00;
			port_power <= 8'h00;
			cool_active <= 8'h00;
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				state[p] <= next_state[p];
				timer[p] <= next_timer[p];
				det_run[p] <= (next_state[p] == ST_DETECT);
				cls_run[p] <= (next_state[p] == ST_CLASS);
				ext_class_run[p] <= (next_state[p] == ST_CLASS_EXT);
				port_power[p] <= (next_state[p] == ST_POWERED);
				cool_active[p] <= (next_state[p] == ST_COOL);
			end
			detect_enable_bit <= next_det_en;
			class_enable_bit <= next_cls_en;
			grant_level <= next_grant;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	for (genvar g = 0; g < NUM_PORTS; g++) begin : g_chk
		AST_OFF_CLEARS: assert property (
			host_power_off[g] && !host_det_set[g] && !host_cls_set[g]
			|=> !detect_enable_bit[g] && !class_enable_bit[g] && !port_power[g])
			else $error("power-off left enables or power set");
		AST_FAULT_COOL: assert property (
			state[g] == ST_POWERED && (start_fault[g] || policing_fault[g]
			|| current_limit_fault[g]) && !host_power_off[g]
			|=> cool_active[g] && !port_power[g])
			else $error("fault did not enter cool-down");
		AST_SHORT_OFF: assert property (
			port_power[g] && short_fault[g] |=> !port_power[g])
			else $error("short did not remove power");
		AST_COOL_HOLD: assert property (
			state[g] == ST_COOL && !(tick && timer[g] == COOL_LAST) && !host_power_off[g]
			|=> state[g] == ST_COOL && !det_run[g] && !cls_run[g])
			else $error("cool-down left early");
		AST_COOL_END: assert property (
			state[g] == ST_COOL && tick && timer[g] == COOL_LAST && !host_power_off[g]
			&& detect_enable_bit[g] |=> det_run[g])
			else $error("detect not restarted after cool-down");
		AST_DISC_RESTART: assert property (
			state[g] == ST_POWERED && maint_drop[g] && !any_fault[g] && !host_power_off[g]
			&& detect_enable_bit[g] |=> det_run[g] && !port_power[g])
			else $error("no restart after disconnect");
		AST_AUTO_DET: assert property (
			auto_on && state[g] == ST_IDLE && !host_power_off[g] |=> det_run[g])
			else $error("autonomous detect not started");
		AST_EXT_HOLD: assert property (
			disable iff (!arst_n || host_power_off[g])
			$rose(ext_class_run[g]) |-> ext_class_run[g] [*8] ##1 !port_power[g])
			else $error("extended class interval cut short");
		AST_EXT_POWER: assert property (
			state[g] == ST_CLASS_EXT && tick && timer[g] == EXT_LAST && !host_power_off[g]
			|=> port_power[g])
			else $error("power not applied after class");
		AST_DEMOTE: assert property (
			auto_on && $rose(ext_class_run[g]) |-> grant_level[2*g +: 2] <= auto_limit)
			else $error("grant exceeds autonomous level");
	end

	AST_ADDR_FROZEN: assert property (
		strap_done |=> $stable(i2c_address) && $stable(auto_mode))
		else $error("strap values changed after capture");

endmodule

// file: shared/poe_seq_pkg.sv
// How it works
// - After a load disconnect, restart detection and classification at once if enabled.
// - Start, policing or current-limit fault sends the port into cool-down.
// - When cool-down expires, restart detect and class cycles if still enabled.
// - Power-off clears both enable bits; host must set them again.
// - Strap: open disables autonomy, 124k gives 15 W, 62k gives 30 W.
// - In autonomy a higher requested class is demoted to the strap level.
// - In autonomy detect runs always; classify only after valid detection.
// - After valid classification, power turns on at the allocated level.
// - Classification ends with a 100 ms extended final interval.
// - Fault load or short removes power; policing guards powered ports.
// - Keep power only with 6 ms qualifying current per 320-400 ms.
// - Slave address comes from four strap pins, unique per bus.
package poe_seq_pkg;

	localparam int NUM_PORTS = 8;
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_NS = 1000000;
	localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
	localparam int TICK_W = 17;
	localparam int MS_CNT_W = 11;
	localparam int CLASS_EXT_MS = 100;
	localparam int MAINT_QUAL_MS = 6;
	localparam int MAINT_WIN_MIN_MS = 320;
	localparam int MAINT_WIN_MAX_MS = 400;
	localparam int COOL_MS_DEFAULT = 1000;
	localparam int SETTLE_W = 2;

	localparam logic [1:0] STRAP_OPEN = 2'h0;
	localparam logic [1:0] STRAP_124K = 2'h1;
	localparam logic [1:0] STRAP_62K = 2'h2;

	localparam logic [1:0] ALLOC_4W = 2'h0;
	localparam logic [1:0] ALLOC_7W = 2'h1;
	localparam logic [1:0] ALLOC_15W = 2'h2;
	localparam logic [1:0] ALLOC_30W = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_DETECT = 3'h1,
		ST_CLASS = 3'h2,
		ST_CLASS_EXT = 3'h3,
		ST_POWERED = 3'h4,
		ST_COOL = 3'h5
	} port_state_type;

	function automatic logic [1:0] class_to_alloc(input logic [2:0] cls);
		case (cls)
			3'h1: class_to_alloc = ALLOC_4W;
			3'h2: class_to_alloc = ALLOC_7W;
			3'h4: class_to_alloc = ALLOC_30W;
			default: class_to_alloc = ALLOC_15W;
		endcase
	endfunction

	function automatic logic [1:0] min_alloc(input logic [1:0] a, input logic [1:0] b);
		min_alloc = (a < b) ? a : b;
	endfunction

	function automatic port_state_type restart_state(input logic det, input logic cls);
		if (det)
			restart_state = ST_DETECT;
		else if (cls)
			restart_state = ST_CLASS;
		else
			restart_state = ST_IDLE;
	endfunction

endpackage

// file: verilog/mps_monitor.sv
`timescale 1ns/1ps
module maint_monitor
	import poe_seq_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic tick,
	input wire logic powered,
	input wire logic current_pin,
	output logic drop
);

	localparam logic [3:0] QUAL_LAST = 4'(MAINT_QUAL_MS - 1);
	localparam logic [MS_CNT_W-1:0] WIN_LAST = MS_CNT_W'(MAINT_WIN_MAX_MS - 1);

	logic cur_meta;
	logic cur_sync;
	logic [3:0] acc;
	logic [MS_CNT_W-1:0] win;
	logic [3:0] next_acc;
	logic [MS_CNT_W-1:0] next_win;
	logic next_drop;

	// ----------------------------------------
	// Qualifying current window
	// ----------------------------------------
	// Window ends at the long limit so a load meeting the short one is never dropped
	always_comb begin
		next_acc = acc;
		next_win = win;
		next_drop = 1'b0;
		if (!powered) begin
			next_acc = '0;
			next_win = '0;
		end else if (tick) begin
			if (cur_sync && acc == QUAL_LAST) begin
				next_acc = '0;
				next_win = '0;
			end else if (win == WIN_LAST) begin
				next_drop = 1'b1;
				next_acc = '0;
				next_win = '0;
			end else begin
				next_acc = cur_sync ? acc + 4'h1 : acc;
				next_win = win + MS_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cur_meta <= 1'b0;
			cur_sync <= 1'b0;
			acc <= '0;
			win <= '0;
			drop <= 1'b0;
		end else begin
			cur_meta <= current_pin;
			cur_sync <= cur_meta;
			acc <= next_acc;
			win <= next_win;
			drop <= next_drop;
		end
	end

	AST_MAINT_DROP: assert property (@(posedge clk) disable iff (!arst_n)
		powered && tick && win == WIN_LAST && !(cur_sync && acc == QUAL_LAST) |=> drop)
		else $error("maintain check did not drop at window end");

endmodule

// file: test/pd_model.sv
`timescale 1ns/1ps
module pd_model
	import poe_seq_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] det_run,
	input wire logic [7:0] cls_run,
	input wire logic [7:0] port_power,
	input wire logic [7:0] sig_ok,
	input wire logic [23:0] cls_req,
	input wire logic [7:0] draw_on,
	input wire logic [7:0] cls_bad,
	input wire logic [3:0] delay,
	output logic [7:0] det_done,
	output logic [7:0] det_ok,
	output logic [7:0] cls_done,
	output logic [7:0] cls_ok,
	output logic [23:0] cls_level,
	output logic [7:0] maint_current_pin
);
	logic [3:0] cnt [8];
	logic [7:0] noise;
	logic [7:0] busy;

	// Results only valid with the done strobe; otherwise lines toggle
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			det_done[i] = det_run[i] && cnt[i] == delay;
			cls_done[i] = cls_run[i] && cnt[i] == delay;
			det_ok[i] = det_done[i] ? sig_ok[i] : noise[i];
			cls_ok[i] = cls_done[i] ? !cls_bad[i] : noise[i];
			cls_level[3*i+:3] = cls_done[i] ? cls_req[3*i+:3] : {3{noise[i]}};
			busy[i] = (det_run[i] || cls_run[i]) && !(det_done[i] || cls_done[i]);
		end
	end

	assign maint_current_pin = port_power & draw_on;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			noise <= 8'h5A;
			for (int i = 0; i < 8; i++)
				cnt[i] <= 4'h0;
		end else begin
			noise <= ~noise;
			for (int i = 0; i < 8; i++)
				cnt[i] <= busy[i] ? cnt[i] + 4'h1 : 4'h0;
		end
	end
endmodule

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import poe_seq_pkg::*;
;
	logic clk;
	logic arst_n;
	logic [1:0] strap;
	logic [1:0] auto_mode;
	logic [3:0] addr;
	logic [3:0] i2c_address;
	logic [3:0] dly;
	logic [7:0] pul [7];
	logic [7:0] st [5];
	logic [7:0] det_done, det_ok, cls_done, cls_ok, maint_pin, sig_ok, draw_on, det_en, cls_en;
	logic [7:0] cls_bad;
	logic [15:0] alloc;
	logic [15:0] grant_level;
	logic [23:0] cls_level;
	logic [23:0] cls_req;
	logic [31:0] seed;
	logic seen;
	int num_errors;
	int checks;
	int p;
	int q;

	poe_port_sequencer #(.TICK_CYCLES(10), .COOL_MS(5)) dut (
		.clk(clk), .arst_n(arst_n), .auto_strap_pin(strap), .address_strap_pins(addr),
		.host_det_set(pul[0]), .host_cls_set(pul[1]), .host_power_off(pul[2]),
		.power_alloc(alloc), .det_done(det_done), .det_ok(det_ok), .cls_done(cls_done),
		.cls_ok(cls_ok), .cls_level(cls_level), .start_fault(pul[3]),
		.policing_fault(pul[4]), .current_limit_fault(pul[5]), .short_fault(pul[6]),
		.maint_current_pin(maint_pin), .i2c_address(i2c_address), .auto_mode(auto_mode),
		.detect_enable_bit(det_en), .class_enable_bit(cls_en), .det_run(st[0]),
		.cls_run(st[1]), .ext_class_run(st[2]), .port_power(st[3]), .cool_active(st[4]),
		.grant_level(grant_level));

	pd_model pd (
		.clk(clk), .arst_n(arst_n), .det_run(st[0]), .cls_run(st[1]), .port_power(st[3]),
		.sig_ok(sig_ok), .cls_req(cls_req), .draw_on(draw_on), .cls_bad(cls_bad),
		.delay(dly),
		.det_done(det_done), .det_ok(det_ok), .cls_done(cls_done), .cls_ok(cls_ok),
		.cls_level(cls_level), .maint_current_pin(maint_pin));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		rnd = seed;
	endfunction

	function automatic logic [1:0] exp_grant(input logic [2:0] c, input logic [1:0] lim);
		logic [1:0] a;
		a = (c == 3'h1) ? 2'h0 : (c == 3'h2) ? 2'h1 : (c == 3'h4) ? 2'h3 : 2'h2;
		exp_grant = (a < lim) ? a : lim;
	endfunction

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic pulse(input int k, input int i);
		@(posedge clk);
		pul[k][i] <= 1'b1;
		@(posedge clk);
		pul[k][i] <= 1'b0;
		#1;
	endtask

	// Bounded poll; a hang shows up as a mismatch, not a stall
	task automatic wait_st(input int k, input int i, input int n, input string what);
		int t;
		t = 0;
		while (st[k][i] !== 1'b1 && t < n) begin
			cyc(1);
			t++;
		end
		chk(what, 1, st[k][i]);
	endtask

	task automatic do_reset(input logic [1:0] s);
		@(posedge clk);
		arst_n <= 1'b0;
		strap <= s;
		addr <= 4'(rnd());
		cyc(10);
		chk("outputs in reset", 0, {st[0], st[3], st[4], det_en});
		@(posedge clk);
		arst_n <= 1'b1;
		cyc(6);
		chk("auto_mode", s, auto_mode);
		chk("i2c_address", addr, i2c_address);
	endtask

	task automatic power_up(input int i);
		pulse(0, i);
		chk("detect enable", 1, det_en[i]);
		pulse(1, i);
		wait_st(2, i, 60, "ext_class_run");
		cyc(980);
		chk("ext class still running", 1, st[2][i]);
		wait_st(3, i, 60, "port_power");
		chk("grant", exp_grant(cls_req[3*i+:3], alloc[2*i+:2]), grant_level[2*i+:2]);
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		seed = 32'h7883;
		arst_n = 1'b0;
		strap = 2'h0;
		addr = 4'h0;
		dly = 4'h0;
		alloc = 16'h0;
		cls_req = 24'h0;
		sig_ok = 8'hFF;
		draw_on = 8'hFF;
		cls_bad = 8'h00;
		for (int k = 0; k < 7; k++)
			pul[k] = 8'h0;
		do_reset(2'h0);
		cyc(500);
		// Distinct ports, so no earlier sequence is still running on the one under test
		q = int'(rnd() % 8);
		for (int k = 3; k < 7; k++) begin
			p = (q + k) % 8;
			@(posedge clk);
			cls_req[3*p+:3] <= 3'(rnd());
			alloc <= 16'(rnd());
			dly <= 4'(rnd() % 8);
			power_up(p);
			pulse(k, p);
			chk("cool_active", 1, st[4][p]);
			chk("power removed", 0, st[3][p]);
			pulse(0, p);
			cyc(30);
			chk("request held", 0, st[0][p]);
			wait_st(0, p, 40, "restart after cool");
			pulse(k, p);
			chk("fault ignored unpowered", 0, st[4][p]);
			$display("fault test %0d done", k);
		end
		pulse(2, p);
		chk("enables cleared", 0, {det_en[p], cls_en[p]});
		cyc(50);
		chk("stays idle", 0, {st[0][p], st[1][p], st[3][p]});
		$display("power off test done");
		// Reuse the port just switched off: it is idle with both enables clear
		power_up(p);
		cyc(4500);
		chk("kept powered", 1, st[3][p]);
		@(posedge clk);
		draw_on[p] <= 1'b0;
		cyc(3200);
		chk("powered within window", 1, st[3][p]);
		wait_st(0, p, 1000, "redetect after drop");
		@(posedge clk);
		draw_on[p] <= 1'b1;
		$display("maintain test done");
		for (int s = 1; s < 3; s++) begin
			p = int'(rnd() % 8);
			q = p ^ 1;
			@(posedge clk);
			cls_req[3*p+:3] <= 3'h4;
			sig_ok <= ~(8'h1 << q);
			cls_bad <= 8'h1 << (p ^ 2);
			do_reset(2'(s));
			seen = 1'b0;
			repeat (1200) begin
				cyc(1);
				seen = seen | st[1][q];
			end
			chk("auto power", 1, st[3][p]);
			chk("failed class unpowered", 0, st[3][p ^ 2]);
			chk("auto grant", exp_grant(3'h4, 2'(s + 1)), grant_level[2*p+:2]);
			chk("no class without detect", 0, seen);
			$display("autonomous test %0d done", s);
		end
		complete_run();
	end

	initial begin
		#(8 * 40000);
		num_errors++;
		$display("[ERR] watchdog expected finish seen hang");
		complete_run();
	end
endmodule
